// file: rtl/cpu_state_consts.svh
`ifndef CPU_STATE_CONSTS_SVH
`define CPU_STATE_CONSTS_SVH

// register byte offsets on the bus
`define OFS_STATUS_WORD 8'h00
`define OFS_STACK_TOP 8'h04
`define OFS_DATA_PTR_LOW 8'h08
`define OFS_DATA_PTR_HIGH 8'h0C
`define OFS_DATA_PTR_FULL 8'h10

// status word field positions
`define SW_CARRY_BIT 7
`define SW_AUX_BIT 6
`define SW_USER0_BIT 5
`define SW_BANK_HI_BIT 4
`define SW_BANK_LO_BIT 3
`define SW_OVF_BIT 2
`define SW_USER1_BIT 1
`define SW_PARITY_BIT 0

// reset values
`define STACK_TOP_RESET 8'h07
`define INSTR_COUNTER_RESET 16'h0000

// working bank geometry: eight bytes per bank
`define BANK_OFFSET_ZEROS 3'h0

// bus responses
`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// file: rtl/cpu_state_pkg.sv
package cpu_state_pkg;
	// whole architectural and bus state in one word
	typedef struct packed {
		logic carry;
		logic aux;
		logic user0;
		logic [1:0] bank;
		logic ovf;
		logic user1;
		logic [7:0] stack_top;
		logic [15:0] data_ptr;
		logic [15:0] instr_cnt;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} core_state_t;
endpackage : cpu_state_pkg

// file: rtl/cpu_state_registers.sv
`timescale 1ns/1ns
`include "cpu_state_consts.svh"
// Summary of operation
// - The two bank-select bits of the status word pick one of four eight-byte working banks at 0x00 to 0x1F.
// - Status bit 0 is computed continuously as the odd parity of the accumulator.
// - Status bits 5 and 1 are user flags written only by software.
// - The stack pointer is eight bits and resets to 0x07.
// - The stack pointer is incremented before each push, so the first push lands at 0x08.
// - The data pointer is sixteen bits with separately addressable low and high bytes.
// - The data pointer loads either as one 16-bit value or byte by byte.
// - The data pointer addresses external data and accumulator-indexed code reads.
// - The instruction counter is sixteen bits and resets to 0x0000.
// - The instruction counter advances on each opcode or operand fetch from program memory, except in a cycle where a jump loads it.
// - The instruction counter has no register address and changes only by sequencing or jumps.
module cpu_state_registers
	import cpu_state_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic [7:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [7:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	output logic s_axi_rready_dummy_out,
	input wire logic s_axi_rready_in,
	input wire logic [7:0] acc_in,
	input wire logic fetch_in,
	input wire logic jump_in,
	input wire logic [15:0] jump_target_in,
	input wire logic flags_we_in,
	input wire logic carry_in,
	input wire logic aux_carry_in,
	input wire logic overflow_in,
	input wire logic push_in,
	input wire logic pop_in,
	input wire logic data_ptr_load_in,
	input wire logic [15:0] data_ptr_value_in,
	output logic [7:0] status_word_out,
	output logic [4:0] bank_base_out,
	output logic [7:0] stack_pointer_out,
	output logic [7:0] stack_write_addr_out,
	output logic [15:0] data_pointer_out,
	output logic [15:0] code_index_addr_out,
	output logic [15:0] instruction_counter_out
);

////////////////////////////////////////////////////////////////////////////////
// helpers

// odd count of ones gives a set flag, so byte plus flag is even
function automatic logic odd_parity(input logic [7:0] v);
	odd_parity = ^v;
endfunction : odd_parity

// status byte as software and the core see it
function automatic logic [7:0] status_byte(input core_state_t st, input logic par);
	logic [7:0] b;
	b = 8'h00;
	b[`SW_CARRY_BIT] = st.carry;
	b[`SW_AUX_BIT] = st.aux;
	b[`SW_USER0_BIT] = st.user0;
	b[`SW_BANK_HI_BIT] = st.bank[1];
	b[`SW_BANK_LO_BIT] = st.bank[0];
	b[`SW_OVF_BIT] = st.ovf;
	b[`SW_USER1_BIT] = st.user1;
	b[`SW_PARITY_BIT] = par;
	status_byte = b;
endfunction : status_byte

// true for the offsets that the bus maps
function automatic logic is_mapped(input logic [7:0] a);
	is_mapped = (a == `OFS_STATUS_WORD) || (a == `OFS_STACK_TOP) || (a == `OFS_DATA_PTR_LOW)
		|| (a == `OFS_DATA_PTR_HIGH) || (a == `OFS_DATA_PTR_FULL);
endfunction : is_mapped

////////////////////////////////////////////////////////////////////////////////
// state

core_state_t s_reg;
core_state_t s_next;
logic parity;
logic wr_go;
logic [7:0] wr_lane0;
logic [7:0] wr_lane1;

// parity follows the accumulator with no storage
assign parity = odd_parity(acc_in);
assign wr_go = s_reg.aw_held && s_reg.w_held;
assign wr_lane0 = s_reg.w_data[7:0];
assign wr_lane1 = s_reg.w_data[15:8];

// next state: bus side first, core side overrides on collision
always_comb begin
	s_next = s_reg;
	if (s_axi_awvalid_in && s_axi_awready_out) begin
		s_next.aw_held = 1'b1;
		s_next.aw_addr = s_axi_awaddr_in;
	end
	if (s_axi_wvalid_in && s_axi_wready_out) begin
		s_next.w_held = 1'b1;
		s_next.w_data = s_axi_wdata_in;
		s_next.w_strb = s_axi_wstrb_in;
	end
	if (s_reg.bvalid && s_axi_bready_in) begin
		s_next.bvalid = 1'b0;
	end
	if (wr_go) begin
		s_next.aw_held = 1'b0;
		s_next.w_held = 1'b0;
		s_next.bvalid = 1'b1;
		s_next.bresp = is_mapped(s_reg.aw_addr) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		case (s_reg.aw_addr)
			`OFS_STATUS_WORD: begin
				if (s_reg.w_strb[0]) begin
					s_next.carry = wr_lane0[`SW_CARRY_BIT];
					s_next.aux = wr_lane0[`SW_AUX_BIT];
					s_next.user0 = wr_lane0[`SW_USER0_BIT];
					s_next.bank = {wr_lane0[`SW_BANK_HI_BIT], wr_lane0[`SW_BANK_LO_BIT]};
					s_next.ovf = wr_lane0[`SW_OVF_BIT];
					s_next.user1 = wr_lane0[`SW_USER1_BIT];
				end
			end
			`OFS_STACK_TOP: begin
				if (s_reg.w_strb[0]) begin
					s_next.stack_top = wr_lane0;
				end
			end
			`OFS_DATA_PTR_LOW: begin
				if (s_reg.w_strb[0]) begin
					s_next.data_ptr[7:0] = wr_lane0;
				end
			end
			`OFS_DATA_PTR_HIGH: begin
				if (s_reg.w_strb[0]) begin
					s_next.data_ptr[15:8] = wr_lane0;
				end
			end
			`OFS_DATA_PTR_FULL: begin
				if (s_reg.w_strb[0]) begin
					s_next.data_ptr[7:0] = wr_lane0;
				end
				if (s_reg.w_strb[1]) begin
					s_next.data_ptr[15:8] = wr_lane1;
				end
			end
			default: begin
			end
		endcase
	end
	// read channel, answered one cycle after the address is taken
	if (s_reg.rvalid && s_axi_rready_in) begin
		s_next.rvalid = 1'b0;
	end
	if (s_axi_arvalid_in && s_axi_arready_out) begin
		s_next.rvalid = 1'b1;
		s_next.rresp = is_mapped(s_axi_araddr_in) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
		case (s_axi_araddr_in)
			`OFS_STATUS_WORD: s_next.rdata = {24'h000000, status_byte(s_reg, parity)};
			`OFS_STACK_TOP: s_next.rdata = {24'h000000, s_reg.stack_top};
			`OFS_DATA_PTR_LOW: s_next.rdata = {24'h000000, s_reg.data_ptr[7:0]};
			`OFS_DATA_PTR_HIGH: s_next.rdata = {24'h000000, s_reg.data_ptr[15:8]};
			`OFS_DATA_PTR_FULL: s_next.rdata = {16'h0000, s_reg.data_ptr};
			default: s_next.rdata = 32'h00000000; // instruction counter deliberately absent
		endcase
	end
	// arithmetic flag update wins over a software write
	if (flags_we_in) begin
		s_next.carry = carry_in;
		s_next.aux = aux_carry_in;
		s_next.ovf = overflow_in;
	end
	// stack grows upward, incremented before the byte is stored
	if (push_in) begin
		s_next.stack_top = s_reg.stack_top + 8'h01;
	end else if (pop_in) begin
		s_next.stack_top = s_reg.stack_top - 8'h01;
	end
	if (data_ptr_load_in) begin
		s_next.data_ptr = data_ptr_value_in;
	end
	// sequencing: a transfer of control beats a plain fetch
	if (jump_in) begin
		s_next.instr_cnt = jump_target_in;
	end else if (fetch_in) begin
		s_next.instr_cnt = s_reg.instr_cnt + 16'h0001;
	end
end

// register the whole state
always_ff @(posedge clk_in) begin
	if (reset_in) begin
		s_reg <= '0;
		s_reg.stack_top <= `STACK_TOP_RESET;
		s_reg.instr_cnt <= `INSTR_COUNTER_RESET;
	end else begin
		s_reg <= s_next;
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

// bus handshakes
assign s_axi_awready_out = !s_reg.aw_held && !s_reg.bvalid;
assign s_axi_wready_out = !s_reg.w_held && !s_reg.bvalid;
assign s_axi_bvalid_out = s_reg.bvalid;
assign s_axi_bresp_out = s_reg.bresp;
assign s_axi_arready_out = !s_reg.rvalid;
assign s_axi_rvalid_out = s_reg.rvalid;
assign s_axi_rdata_out = s_reg.rdata;
assign s_axi_rresp_out = s_reg.rresp;
assign s_axi_rready_dummy_out = 1'b0;

// core-facing views of the state
assign status_word_out = status_byte(s_reg, parity);
assign bank_base_out = {s_reg.bank, `BANK_OFFSET_ZEROS};
assign stack_pointer_out = s_reg.stack_top;
assign stack_write_addr_out = s_reg.stack_top + 8'h01;
assign data_pointer_out = s_reg.data_ptr;
assign code_index_addr_out = s_reg.data_ptr + {8'h00, acc_in};
assign instruction_counter_out = s_reg.instr_cnt;

////////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge clk_in);
endclocking
default disable iff (reset_in);

property p_bank_map;
	wr_go && s_reg.aw_addr == `OFS_STATUS_WORD && s_reg.w_strb[0]
		|=> bank_base_out == {$past(wr_lane0[`SW_BANK_HI_BIT]), $past(wr_lane0[`SW_BANK_LO_BIT]), `BANK_OFFSET_ZEROS};
endproperty
a_bank_map: assert property (p_bank_map) else $error("bank base wrong after status write");

property p_parity;
	status_word_out[`SW_PARITY_BIT] == ^acc_in;
endproperty
a_parity: assert property (p_parity) else $error("parity flag wrong");

property p_user_flags;
	!(wr_go && s_reg.aw_addr == `OFS_STATUS_WORD)
		|=> status_word_out[`SW_USER0_BIT] == $past(status_word_out[`SW_USER0_BIT])
		&& status_word_out[`SW_USER1_BIT] == $past(status_word_out[`SW_USER1_BIT]);
endproperty
a_user_flags: assert property (p_user_flags) else $error("user flag changed without write");

property p_stack_reset;
	@(posedge clk_in) disable iff (1'b0) reset_in |=> stack_pointer_out == `STACK_TOP_RESET;
endproperty
a_stack_reset: assert property (p_stack_reset) else $error("stack pointer reset value wrong");

property p_push;
	push_in |-> stack_write_addr_out == stack_pointer_out + 8'h01 ##1 stack_pointer_out == $past(stack_write_addr_out);
endproperty
a_push: assert property (p_push) else $error("push did not pre-increment");

property p_high_byte;
	wr_go && s_reg.aw_addr == `OFS_DATA_PTR_HIGH && s_reg.w_strb[0] && !data_ptr_load_in
		|=> data_pointer_out == {$past(wr_lane0), $past(data_pointer_out[7:0])};
endproperty
a_high_byte: assert property (p_high_byte) else $error("high byte write disturbed pointer");

property p_load16;
	data_ptr_load_in |=> data_pointer_out == $past(data_ptr_value_in) ##1 $stable(data_pointer_out) || $past(wr_go)
		|| $past(data_ptr_load_in);
endproperty
a_load16: assert property (p_load16) else $error("pointer load failed");

property p_code_index;
	code_index_addr_out == data_pointer_out + {8'h00, acc_in};
endproperty
a_code_index: assert property (p_code_index) else $error("indexed code address wrong");

property p_counter_reset;
	@(posedge clk_in) disable iff (1'b0) reset_in |=> instruction_counter_out == `INSTR_COUNTER_RESET;
endproperty
a_counter_reset: assert property (p_counter_reset) else $error("counter reset value wrong");

property p_fetch;
	fetch_in && !jump_in |=> instruction_counter_out == $past(instruction_counter_out) + 16'h0001;
endproperty
a_fetch: assert property (p_fetch) else $error("fetch did not advance counter");

property p_counter_hold;
	!fetch_in && !jump_in |=> $stable(instruction_counter_out);
endproperty
a_counter_hold: assert property (p_counter_hold) else $error("counter moved on its own");

property p_flags;
	flags_we_in |=> status_word_out[`SW_CARRY_BIT] == $past(carry_in) && status_word_out[`SW_AUX_BIT] == $past(aux_carry_in)
		&& status_word_out[`SW_OVF_BIT] == $past(overflow_in);
endproperty
a_flags: assert property (p_flags) else $error("arithmetic flags not loaded");

c_write: cover property (s_axi_bvalid_out && s_axi_bready_in && s_axi_bresp_out == `AXI_RESP_OKAY);
c_read: cover property (s_axi_rvalid_out && s_axi_rready_in && s_axi_rresp_out == `AXI_RESP_OKAY);
c_push: cover property (push_in ##1 push_in);
c_jump: cover property (fetch_in ##1 jump_in);

endmodule : cpu_state_registers

// file: test/cpu_state_registers_bench.sv
`timescale 1ns/1ns
`include "cpu_state_consts.svh"
module cpu_state_registers_bench;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic [3:0] s;
		logic [31:0] e;
		logic [1:0] r;
	} row_t;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, acc = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic fetch = 0, jump = 0, fwe = 0, cy = 0, ac = 0, ov = 0, push = 0, pop = 0, dpld = 0;
	logic [15:0] jt = 16'h0, dpv = 16'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] status, sp, swa;
	logic [4:0] bank;
	logic [15:0] dp, cia, ic;
	logic spare;
	int fail_count = 0;
	int n_compared = 0;
	// write, read back: byte lanes, 16-bit pair, unmapped place, empty strobe
	// the parity bit written as one must read back from the accumulator (zero here)
	row_t rows [8] = '{
		'{`OFS_STATUS_WORD, 32'hFF, 4'h1, 32'hFE, `AXI_RESP_OKAY},
		'{`OFS_STACK_TOP, 32'h55, 4'h1, 32'h55, `AXI_RESP_OKAY},
		'{`OFS_DATA_PTR_LOW, 32'h34, 4'h1, 32'h34, `AXI_RESP_OKAY},
		'{`OFS_DATA_PTR_FULL, 32'h5678, 4'h3, 32'h5678, `AXI_RESP_OKAY},
		'{`OFS_DATA_PTR_HIGH, 32'h12, 4'h1, 32'h12, `AXI_RESP_OKAY},
		'{`OFS_DATA_PTR_FULL, 32'hBEEF, 4'h1, 32'h12EF, `AXI_RESP_OKAY},
		'{8'h14, 32'hAA, 4'h1, 32'h0, `AXI_RESP_SLVERR},
		'{`OFS_STACK_TOP, 32'h99, 4'h0, 32'h55, `AXI_RESP_OKAY}};
	logic [7:0] accs [5] = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hFF};

	cpu_state_registers i_cpu_state_registers (
		.clk_in(clk_in), .reset_in(reset_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_dummy_out(spare), .s_axi_rready_in(rready),
		.acc_in(acc), .fetch_in(fetch), .jump_in(jump), .jump_target_in(jt),
		.flags_we_in(fwe), .carry_in(cy), .aux_carry_in(ac), .overflow_in(ov),
		.push_in(push), .pop_in(pop), .data_ptr_load_in(dpld), .data_ptr_value_in(dpv),
		.status_word_out(status), .bank_base_out(bank), .stack_pointer_out(sp),
		.stack_write_addr_out(swa), .data_pointer_out(dp), .code_index_addr_out(cia),
		.instruction_counter_out(ic)
	);

	////////////////////////////////////////////////////////////////////////////////
	// clock generator
	initial begin
		forever #5 clk_in = ~clk_in;
	end

	// count a comparison, report a mismatch
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// bus write: readiness sampled mid-cycle, taken at the next rising edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic ta, tw, b;
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk_in);
			ta = awvalid && awready;
			tw = wvalid && wready;
			b = bvalid;
			r = bresp;
			@(posedge clk_in);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
	endtask : axi_wr

	// bus read: data and response taken at the edge where rvalid is high
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t, v;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk_in);
			t = arvalid && arready;
			v = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_in);
			if (t) arvalid <= 1'b0;
		end while (!v);
		rready <= 1'b0;
	endtask : axi_rd

	// verdict and end of run
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial begin
		#200000;
		fail_count++;
		wrap_up();
	end

	// main sequence
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		@(negedge clk_in);
		chk("stack_pointer", 8'h07, sp);
		chk("stack_write_addr", 8'h08, swa);
		chk("instr_counter", 16'h0000, ic);
		chk("spare", 32'h0, spare);
		foreach (rows[i]) begin
			axi_wr(rows[i].a, rows[i].d, rows[i].s, r);
			chk("bresp", rows[i].r, r);
			axi_rd(rows[i].a, d, r);
			chk("rdata", rows[i].e, d);
			chk("rresp", rows[i].r, r);
		end
		for (int k = 0; k < 4; k++) begin
			axi_wr(`OFS_STATUS_WORD, 32'(k << 3), 4'h1, r);
			@(negedge clk_in);
			chk("bank_base", 32'(k * 8), bank);
		end
		foreach (accs[i]) begin
			@(posedge clk_in);
			acc <= accs[i];
			@(negedge clk_in);
			chk("parity", ^accs[i], status[0]);
			chk("code_index", 16'h12EF + 16'(accs[i]), cia);
		end
		// hardware flag load, then a clearing load: user flags stay put
		axi_wr(`OFS_STATUS_WORD, 32'h22, 4'h1, r);
		for (int j = 0; j < 2; j++) begin
			@(posedge clk_in);
			{cy, ac, ov} <= {3{j == 0}};
			fwe <= 1'b1;
			@(posedge clk_in);
			fwe <= 1'b0;
			@(negedge clk_in);
			chk("status_flags", (j == 0) ? 7'h73 : 7'h11, status[7:1]);
		end
		@(posedge clk_in);
		fetch <= 1'b1;
		repeat (3) @(posedge clk_in);
		fetch <= 1'b0;
		@(negedge clk_in);
		chk("instr_counter", 16'h0003, ic);
		@(posedge clk_in);
		jump <= 1'b1;
		jt <= 16'hABCD;
		fetch <= 1'b1;
		@(posedge clk_in);
		jump <= 1'b0;
		@(posedge clk_in);
		fetch <= 1'b0;
		@(negedge clk_in);
		chk("instr_counter", 16'hABCE, ic);
		@(posedge clk_in);
		dpld <= 1'b1;
		dpv <= 16'hCAFE;
		@(posedge clk_in);
		dpld <= 1'b0;
		@(negedge clk_in);
		chk("data_pointer", 16'hCAFE, dp);
		axi_rd(`OFS_DATA_PTR_HIGH, d, r);
		chk("ptr_high", 32'hCA, d);
		// second reset in mid-run, then stack pre-increment
		@(posedge clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		@(negedge clk_in);
		chk("stack_pointer", 8'h07, sp);
		chk("instr_counter", 16'h0000, ic);
		@(posedge clk_in);
		push <= 1'b1;
		@(posedge clk_in);
		push <= 1'b0;
		@(negedge clk_in);
		chk("stack_pointer", 8'h08, sp);
		chk("stack_write_addr", 8'h09, swa);
		// push and pop together: push wins; then a lone pop steps back
		@(posedge clk_in);
		push <= 1'b1;
		pop <= 1'b1;
		@(posedge clk_in);
		push <= 1'b0;
		@(negedge clk_in);
		chk("stack_pointer", 8'h09, sp);
		@(posedge clk_in);
		pop <= 1'b0;
		@(negedge clk_in);
		chk("stack_pointer", 8'h08, sp);
		wrap_up();
	end
endmodule : cpu_state_registers_bench
